/* File: logic/ctu_defines.vh */
// register offsets, field positions and reset values of the charge time edge control block
// Operation
// - edge-1 status reads occurrence; writes drive it
// - edge-2 sensing: one edge, zero level
// - edge-2 polarity: one rising, zero falling
// - four-bit field selects one of sixteen sources
// - bits 17 and 16 read zero
// - module enable turns unit on
// - bit 14 reads zero
// - halt-when-idle stops unit during idle
// - delay-pulse enable gates delay pulse generation
// - edge pass enable blocks or passes edges
// - discharge sink only when discharge bit set
`ifndef CTU_DEFINES_VH
`define CTU_DEFINES_VH
`define CTU_ADDR_CTRL         12'h000
`define CTU_ADDR_IRQ_STATUS   12'h004
`define CTU_ADDR_IRQ_MASK     12'h008
`define CTU_BIT_FIRST_SEEN    24
`define CTU_BIT_SENSING       23
`define CTU_BIT_POLARITY      22
`define CTU_SRC_HI            21
`define CTU_SRC_LO            18
`define CTU_BIT_ENABLE        15
`define CTU_BIT_HALT_IDLE     13
`define CTU_BIT_DELAY_EN      12
`define CTU_BIT_EDGE_PASS     11
`define CTU_BIT_DISCHARGE     1
`define CTU_CTRL_WMASK        32'h01fcb802
`define CTU_CTRL_RESET        32'h00000000
`define CTU_IRQ_BITS          2
`define CTU_IRQ_FIRST         0
`define CTU_IRQ_SECOND        1
`define CTU_SRC_COMP_TWO      4'he
`endif

/* File: logic/ctu_edge_control.v */
// charge time unit edge control: apb registers, edge source select, edge detect, interrupts
`include "ctu_defines.vh"
module ctu_edge_control (
	// clock and reset
	input  wire        ref_clk_in,
	input  wire        rst_n_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	input  wire [3:0]  pstrb_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// edge sources
	input  wire        timer_one_event_in,
	input  wire        compare_one_event_in,
	input  wire [6:0]  edge_pin_in,
	input  wire [2:0]  capture_event_in,
	input  wire        peripheral_bus_clock_in,
	input  wire [2:0]  comparator_output_in,
	// system state
	input  wire        idle_mode_in,
	// outputs
	output reg         second_edge_hit_out,
	output reg         delay_pulse_out,
	output reg         sample_cap_discharge_out,
	output reg         unit_active_out,
	output reg         irq_out
);
	reg  [31:0] ctrl;
	reg  [1:0]  irq_status;
	reg  [1:0]  irq_mask;
	reg         src_prev;
	reg         first_seen_prev;
	reg  [15:0] src_vec;
	wire        first_edge_seen      = ctrl[`CTU_BIT_FIRST_SEEN];
	wire        second_edge_sensing  = ctrl[`CTU_BIT_SENSING];
	wire        second_edge_polarity = ctrl[`CTU_BIT_POLARITY];
	wire [3:0]  second_edge_source   = ctrl[`CTU_SRC_HI:`CTU_SRC_LO];
	wire        halt_when_idle       = ctrl[`CTU_BIT_HALT_IDLE];
	wire        delay_pulse_enable   = ctrl[`CTU_BIT_DELAY_EN];
	wire        edge_pass_enable     = ctrl[`CTU_BIT_EDGE_PASS];
	wire        sample_cap_discharge = ctrl[`CTU_BIT_DISCHARGE];
	wire        module_on            = ctrl[`CTU_BIT_ENABLE];
	// unit runs only when on and not halted by idle
	wire        running  = module_on & ~(halt_when_idle & idle_mode_in);
	wire        gate     = running & edge_pass_enable;
	wire        src_raw;
	wire        src_pol;
	wire        second_hit;
	wire        wr_en    = psel_in & penable_in & pwrite_in & pready_out;
	reg         mapped;
	wire [31:0] byte_mask;
	wire        first_rise;
	reg  [31:0] next_ctrl;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_status;
	genvar      gi;

	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign byte_mask[gi*8 +: 8] = {8{pstrb_in[gi]}};
		end
	endgenerate

	// sixteen-way source select, code 4'hf down to 4'h0
	always @* begin
		// comparators and bus clock
		src_vec[15] = comparator_output_in[2];
		src_vec[14] = comparator_output_in[1];
		src_vec[13] = comparator_output_in[0];
		src_vec[12] = peripheral_bus_clock_in;
		// capture events
		src_vec[11] = capture_event_in[2];
		src_vec[10] = capture_event_in[1];
		src_vec[9]  = capture_event_in[0];
		// edge pins
		src_vec[8]  = edge_pin_in[6];
		src_vec[7]  = edge_pin_in[5];
		src_vec[6]  = edge_pin_in[4];
		src_vec[5]  = edge_pin_in[3];
		src_vec[4]  = edge_pin_in[2];
		// the two lowest pins sit in swapped code order
		src_vec[3]  = edge_pin_in[0];
		src_vec[2]  = edge_pin_in[1];
		src_vec[1]  = compare_one_event_in;
		src_vec[0]  = timer_one_event_in;
	end
	assign src_raw = src_vec[second_edge_source];
	assign src_pol = second_edge_polarity ? src_raw : ~src_raw;
	// edge mode looks for a transition to the active level, level mode for the level itself
	assign second_hit = gate & (second_edge_sensing ? (src_pol & ~src_prev) : src_pol);
	assign first_rise = first_edge_seen & ~first_seen_prev;

	always @* begin
		next_ctrl = ctrl;
		if (wr_en && paddr_in == `CTU_ADDR_CTRL) begin
			next_ctrl = (ctrl & ~(byte_mask & `CTU_CTRL_WMASK)) |
			            (pwdata_in & byte_mask & `CTU_CTRL_WMASK);
		end
		// a second edge with delay pulses enabled marks the first edge as seen
		if (second_hit && delay_pulse_enable) begin
			next_ctrl[`CTU_BIT_FIRST_SEEN] = 1'b1;
		end
	end

	always @* begin
		next_status = irq_status;
		if (wr_en && paddr_in == `CTU_ADDR_IRQ_STATUS && pstrb_in[0]) begin
			next_status = irq_status & ~pwdata_in[1:0];
		end
		// set wins over clear
		if (first_rise && running) begin
			next_status[`CTU_IRQ_FIRST] = 1'b1;
		end
		if (second_hit) begin
			next_status[`CTU_IRQ_SECOND] = 1'b1;
		end
	end

	always @* begin
		next_rdata = 32'h00000000;
		case (paddr_in)
			`CTU_ADDR_CTRL: begin
				next_rdata                          = 32'h00000000;
				next_rdata[`CTU_BIT_FIRST_SEEN]     = first_edge_seen;
				next_rdata[`CTU_BIT_SENSING]        = second_edge_sensing;
				next_rdata[`CTU_BIT_POLARITY]       = second_edge_polarity;
				next_rdata[`CTU_SRC_HI:`CTU_SRC_LO] = second_edge_source;
				next_rdata[`CTU_BIT_ENABLE]         = module_on;
				next_rdata[`CTU_BIT_HALT_IDLE]      = halt_when_idle;
				next_rdata[`CTU_BIT_DELAY_EN]       = delay_pulse_enable;
				next_rdata[`CTU_BIT_EDGE_PASS]      = edge_pass_enable;
				next_rdata[`CTU_BIT_DISCHARGE]      = sample_cap_discharge;
			end
			`CTU_ADDR_IRQ_STATUS: begin
				next_rdata                  = 32'h00000000;
				next_rdata[`CTU_IRQ_FIRST]  = irq_status[`CTU_IRQ_FIRST];
				next_rdata[`CTU_IRQ_SECOND] = irq_status[`CTU_IRQ_SECOND];
			end
			`CTU_ADDR_IRQ_MASK: begin
				next_rdata                  = 32'h00000000;
				next_rdata[`CTU_IRQ_FIRST]  = irq_mask[`CTU_IRQ_FIRST];
				next_rdata[`CTU_IRQ_SECOND] = irq_mask[`CTU_IRQ_SECOND];
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	reg         next_prev;
	reg  [1:0]  next_mask;
	reg         next_ready;
	reg         next_slverr;
	reg  [31:0] next_prdata;
	reg         next_hit;
	reg         next_delay;
	reg         next_sink;
	reg         next_active;
	reg         next_irq;

	// only the three words below answer without an error
	always @* begin
		mapped = 1'b0;
		case (paddr_in)
			`CTU_ADDR_CTRL: begin
				mapped = 1'b1;
			end
			`CTU_ADDR_IRQ_STATUS: begin
				mapped = 1'b1;
			end
			`CTU_ADDR_IRQ_MASK: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// held at the gated level so that opening the gate on an active level is no edge
	always @* begin
		next_prev = 1'b1;
		if (gate) begin
			next_prev = src_pol;
		end
	end

	// mask register, low byte lane only
	always @* begin
		next_mask = irq_mask;
		if (wr_en && paddr_in == `CTU_ADDR_IRQ_MASK && pstrb_in[0]) begin
			next_mask = pwdata_in[1:0];
		end
	end

	// one wait state: ready in the second access cycle
	always @* begin
		next_ready  = psel_in & penable_in & ~pready_out;
		next_slverr = psel_in & penable_in & ~pready_out & ~mapped;
	end

	// read data is captured in the first access cycle
	always @* begin
		next_prdata = prdata_out;
		if (psel_in && penable_in && !pready_out && !pwrite_in) begin
			next_prdata = next_rdata;
		end
	end

	// event outputs
	always @* begin
		next_hit   = second_hit;
		next_delay = second_hit & delay_pulse_enable;
	end

	// level outputs
	always @* begin
		next_sink   = sample_cap_discharge;
		next_active = running;
		next_irq    = |(next_status & irq_mask);
	end

	// control register
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= `CTU_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// interrupt status and mask
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
		end else begin
			irq_status <= next_status;
			irq_mask   <= next_mask;
		end
	end

	// selected source history, reset to the gated level
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			src_prev <= 1'b1;
		end else begin
			src_prev <= next_prev;
		end
	end

	// edge-1 status history for its rising edge
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			first_seen_prev <= 1'b0;
		end else begin
			first_seen_prev <= first_edge_seen;
		end
	end

	// bus handshake
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= next_ready;
			pslverr_out <= next_slverr;
		end
	end

	// read data holds until the next read
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h00000000;
		end else begin
			prdata_out <= next_prdata;
		end
	end

	// edge event outputs
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			second_edge_hit_out <= 1'b0;
			delay_pulse_out     <= 1'b0;
		end else begin
			second_edge_hit_out <= next_hit;
			delay_pulse_out     <= next_delay;
		end
	end

	// level outputs
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_cap_discharge_out <= 1'b0;
			unit_active_out          <= 1'b0;
			irq_out                  <= 1'b0;
		end else begin
			sample_cap_discharge_out <= next_sink;
			unit_active_out          <= next_active;
			irq_out                  <= next_irq;
		end
	end
endmodule

/* File: dv/ctu_edge_control_monitor.sv */
// assertion checker on the edge control block ports
module ctu_edge_control_monitor (
	// bus side
	input wire logic        ref_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] prdata_out,
	// unit side
	input wire logic        second_edge_hit_out, delay_pulse_out, sample_cap_discharge_out, unit_active_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	answer_time_a: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("late answer");
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready too long");
	err_ready_a: assert property (pslverr_out |-> pready_out) else $error("error without ready");
	unmapped_err_a: assert property (pready_out && paddr_in > 12'h008 |-> pslverr_out) else $error("no error");
	err_data_a: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("error data");
	reserved_zero_a:
		assert property (pready_out && !pwrite_in |-> {prdata_out[17:16], prdata_out[14]} == 3'h0) else $error("reserved");
	delay_hit_a: assert property (delay_pulse_out |-> second_edge_hit_out) else $error("delay alone");
	off_quiet_a:
		assert property (!unit_active_out && !$past(unit_active_out) |-> !delay_pulse_out) else $error("delay while off");
	discharge_write_a:
		assert property ($rose(sample_cap_discharge_out) |-> $past(pready_out) || $past(pready_out, 2)) else $error("sink");
endmodule
bind ctu_edge_control ctu_edge_control_monitor ctu_edge_control_monitor_i (.*);

/* File: dv/ctu_edge_sources.sv */
// behavioural model of the on-chip edge sources feeding the unit
module ctu_edge_sources (
	input  wire logic        clk_in,
	output logic      [15:0] src_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial src_out = 16'h0000;
	// sources move just after a clock edge, as on-chip peripherals do
	task automatic set_src(input logic [3:0] code, input logic lvl);
		@(posedge clk_in);
		src_out[code] <= lvl;
	endtask
endmodule

/* File: dv/ctu_edge_control_tb.sv */
// self-checking bench of the charge time edge control block
`include "ctu_defines.vh"
module ctu_edge_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, idle = 0, er;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic        prdy, perr, hit, dly, dis, act, irq;
	logic [15:0] src;
	int          fail_count = 0, n_compared = 0;
	localparam logic [31:0] ON = 32'h0000_8800, POS = 32'h0040_0000;
	always #2 clk = ~clk;
	ctu_edge_sources ctu_edge_sources_i (.clk_in(clk), .src_out(src));
	ctu_edge_control ctu_edge_control_i (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .timer_one_event_in(src[0]), .compare_one_event_in(src[1]),
		.edge_pin_in({src[8:4], src[2], src[3]}), .capture_event_in(src[11:9]), .peripheral_bus_clock_in(src[12]),
		.comparator_output_in(src[15:13]), .idle_mode_in(idle), .second_edge_hit_out(hit), .delay_pulse_out(dly),
		.sample_cap_discharge_out(dis), .unit_active_out(act), .irq_out(irq));
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwr, pa, pwd} <= {1'b1, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		{psel, pen} <= 2'b00;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 12'h000, 0);
		chk("ctrl reset", 32'h0, rd);
		for (int i = 0; i < 2; i++) begin
			apb(1, 12'h000, i ? 32'h0 : 32'hffff_ffff);
			apb(0, 12'h000, 0);
			chk("ctrl", i ? 32'h0 : `CTU_CTRL_WMASK, rd);
			tick(2);
			chk("sink", i ? 32'h0 : 32'h1, dis);
		end
		for (int c = 0; c < 16; c++) begin
			apb(1, 12'h000, ON | POS | (c << 18));
			ctu_edge_sources_i.set_src(c[3:0], 1);
			tick(2);
			chk("level hit", 1, hit);
			chk("irq masked", 0, irq);
			ctu_edge_sources_i.set_src(c[3:0], 0);
			tick(2);
			chk("level low", 0, hit);
		end
		apb(1, 12'h000, ON | 32'h0080_0000 | (3 << 18));
		ctu_edge_sources_i.set_src(3, 1);
		tick(2);
		ctu_edge_sources_i.set_src(3, 0);
		tick(1);
		chk("fall hit", 1, hit);
		tick(1);
		chk("pulse end", 0, hit);
		ctu_edge_sources_i.set_src(0, 1);
		for (int k = 0; k < 2; k++) begin
			apb(1, 12'h000, POS | (k ? 32'h0800 : 32'h8000));
			tick(2);
			chk("blocked", 0, hit);
			chk("active", k ? 0 : 1, act);
		end
		ctu_edge_sources_i.set_src(0, 0);
		for (int h = 0; h < 2; h++) begin
			apb(1, 12'h000, ON | POS | (h << 13));
			@(posedge clk) idle <= 1'b1;
			tick(2);
			chk("idle active", h ? 0 : 1, act);
			@(posedge clk) idle <= 1'b0;
		end
		apb(1, 12'h004, 32'h3);
		apb(1, 12'h008, 32'h2);
		tick(2);
		chk("irq idle", 0, irq);
		apb(1, 12'h000, ON | POS | 32'h1000 | (`CTU_SRC_COMP_TWO << 18));
		ctu_edge_sources_i.set_src(14, 1);
		tick(2);
		chk("delay", 1, dly);
		chk("irq", 1, irq);
		apb(0, 12'h000, 0);
		chk("first seen", 1, rd[24]);
		ctu_edge_sources_i.set_src(14, 0);
		apb(1, 12'h004, 32'h2);
		tick(2);
		chk("irq clear", 0, irq);
		apb(0, 12'h00c, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		wrap_up();
	end
	initial begin
		#20000;
		fail_count++;
		wrap_up();
	end
endmodule
